// ---- hw/swc_sleep_wakeup_control.sv ----
// sleep entry, wake-up control and the last two peripheral request flag registers
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "swc_regs.svh"
module swc_sleep_wakeup_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic [15:0] core_pc,
  input wire logic capcomp3_event,
  input wire logic [3:0] pwm_timebase_event,
  input wire logic [3:0] pwm_shutdown_event,
  input wire logic ext_irq_wake,
  input wire logic watchdog_timeout,
  input wire logic master_reset_pin_n,
  input wire logic master_reset_enable,
  input wire logic brownout_reset,
  input wire logic brownout_enable,
  input wire logic osc_tick,
  input wire logic [1:0] timer1_clk_sel,
  input wire logic converter_internal_osc_sel,
  output logic cpu_clk_en,
  output logic watchdog_clear,
  output logic watchdog_run_en,
  output logic low_freq_internal_osc_en,
  output logic converter_osc_en,
  output logic timer1_run_en,
  output logic io_hold,
  output logic [15:0] prefetch_addr,
  output logic full_reset_req,
  output logic [15:0] vector_addr,
  output swc_pkg::swc_wake_s wake_info,
  output logic peripheral_irq_req
);
  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic master_reset_pin_n_q;
  logic bor_q;
  logic ext_q;
  // async pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 3'h1;
      pin_s2_r <= 3'h1;
    end else begin
      pin_s1_r <= {ext_irq_wake, brownout_reset, master_reset_pin_n};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign master_reset_pin_n_q = pin_s2_r[0];
  assign bor_q = pin_s2_r[1];
  assign ext_q = pin_s2_r[2];

  // ==========================================================
  // apb slave
  // ==========================================================
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] flags3_r;
  logic [7:0] pwmflags_r;
  logic [7:0] enable3_r;
  logic [7:0] enable4_r;
  logic [7:0] ctrl_r;
  logic to_r;
  logic pd_r;
  swc_pkg::swc_state_e state_r;
  swc_pkg::swc_state_e state_nxt;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      `SWC_FLAGS3_OFF, `SWC_PWMFLAGS_OFF, `SWC_ENABLE3_OFF, `SWC_ENABLE4_OFF,
      `SWC_CTRL_OFF, `SWC_STATUS_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // unmapped addresses answer with an error, zero data
  assign pslverr = psel && penable && !mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SWC_FLAGS3_OFF: prdata <= {24'h00_0000, flags3_r};
        `SWC_PWMFLAGS_OFF: prdata <= {24'h00_0000, pwmflags_r};
        `SWC_ENABLE3_OFF: prdata <= {24'h00_0000, enable3_r};
        `SWC_ENABLE4_OFF: prdata <= {24'h00_0000, enable4_r};
        `SWC_CTRL_OFF: prdata <= {24'h00_0000, ctrl_r};
        `SWC_STATUS_OFF: prdata <= {27'h000_0000, to_r, pd_r, 2'h0, state_r != swc_pkg::SWC_RUN};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;

  // ==========================================================
  // request flags
  // ==========================================================
  // hardware set beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags3_r <= `SWC_FLAGS_RST;
    end else begin
      if (wr_en && paddr == `SWC_FLAGS3_OFF) begin
        flags3_r[`SWC_CAPCOMP3_BIT] <= pwdata[`SWC_CAPCOMP3_BIT] | capcomp3_event;
      end else if (capcomp3_event) begin
        flags3_r[`SWC_CAPCOMP3_BIT] <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwmflags_r <= `SWC_FLAGS_RST;
    end else if (wr_en && paddr == `SWC_PWMFLAGS_OFF) begin
      pwmflags_r <= pwdata[7:0] | {pwm_timebase_event, pwm_shutdown_event};
    end else begin
      pwmflags_r <= pwmflags_r | {pwm_timebase_event, pwm_shutdown_event};
    end
  end
  // third enable register: only the capture/compare 3 bit exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable3_r <= `SWC_FLAGS_RST;
    end else if (wr_en && paddr == `SWC_ENABLE3_OFF) begin
      enable3_r <= {3'h0, pwdata[`SWC_CAPCOMP3_BIT], 4'h0};
    end
  end
  // fourth enable register mirrors the pwm flag layout bit for bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable4_r <= `SWC_FLAGS_RST;
    end else if (wr_en && paddr == `SWC_ENABLE4_OFF) begin
      enable4_r <= pwdata[7:0];
    end
  end
  // control: global, peripheral, watchdog-in-sleep and crystal mode bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SWC_CTRL_RST;
    end else if (wr_en && paddr == `SWC_CTRL_OFF) begin
      ctrl_r <= {4'h0, pwdata[3:0]};
    end
  end

  // ==========================================================
  // wake request
  // ==========================================================
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic periph_pending;
  logic irq_pending;
  assign global_irq_enable = ctrl_r[`SWC_CTRL_GIE_BIT];
  assign peripheral_irq_enable = ctrl_r[`SWC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
  // global enable plays no part in waking
  assign periph_pending = peripheral_irq_enable && (|(flags3_r & enable3_r) || |(pwmflags_r & enable4_r));
  assign irq_pending = periph_pending || ext_q;
  assign peripheral_irq_req = periph_pending;

  // ==========================================================
  // sleep sequencer
  // ==========================================================
  logic wdt_wake;
  logic reset_src;
  logic [10:0] ost_cnt_r;
  logic ost_done;
  logic enter_ok;
  assign wdt_wake = watchdog_timeout && ctrl_r[`SWC_CTRL_WDTSLP_BIT];
  // reset sources act the same awake or asleep
  assign reset_src = (master_reset_enable && !master_reset_pin_n_q) || (brownout_enable && bor_q);
  assign ost_done = ost_cnt_r == 11'(`SWC_OST_PERIODS);
  // pending flag with global off turns sleep into a no-op
  assign enter_ok = sleep_instr && !(irq_pending && !global_irq_enable);
  logic entering;
  // the one cycle in which a real sleep begins
  assign entering = state_r == swc_pkg::SWC_RUN && enter_ok;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swc_pkg::SWC_RUN: begin
        if (enter_ok) begin
          state_nxt = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        // flag arriving during the instruction wakes at once
        if (irq_pending || wdt_wake) begin
          state_nxt = ctrl_r[`SWC_CTRL_XTAL_BIT] ? swc_pkg::SWC_OST : swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_OST: begin
        if (ost_done) begin
          state_nxt = swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_RESUME: state_nxt = swc_pkg::SWC_RUN;
      default: state_nxt = swc_pkg::SWC_RUN;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= swc_pkg::SWC_RUN;
    end else if (reset_src) begin
      state_r <= swc_pkg::SWC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  // start-up delay counts oscillator periods, not pclk cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_cnt_r <= 11'h000;
    end else if (state_r != swc_pkg::SWC_OST) begin
      ost_cnt_r <= 11'h000;
    end else if (osc_tick && !ost_done) begin
      ost_cnt_r <= ost_cnt_r + 11'h001;
    end
  end
  // time-out bit: set on entry, cleared only by a watchdog wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_r <= 1'b1;
    end else if (reset_src) begin
      to_r <= 1'b1;
    end else if (entering) begin
      to_r <= 1'b1;
    end else if (state_r == swc_pkg::SWC_SLEEP && wdt_wake) begin
      to_r <= 1'b0;
    end
  end
  // power-down bit: cleared on a real entry, set again only by reset; a no-op sleep leaves it unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r <= 1'b1;
    end else if (reset_src) begin
      pd_r <= 1'b1;
    end else if (entering) begin
      pd_r <= 1'b0;
    end
  end
  // watchdog clear on entry and on every wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= (state_r == swc_pkg::SWC_RUN && enter_ok)
        || (state_r == swc_pkg::SWC_SLEEP && state_nxt != swc_pkg::SWC_SLEEP);
    end
  end
  // prefetch captures pc+1 as the instruction executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_addr <= 16'h0000;
    end else if (sleep_instr) begin
      prefetch_addr <= core_pc + 16'h0001;
    end
  end
  // resume pulse tells the core how to continue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_info <= '0;
    end else begin
      wake_info.resume <= state_r == swc_pkg::SWC_RESUME;
      wake_info.take_vector <= state_r == swc_pkg::SWC_RESUME && global_irq_enable && irq_pending;
      wake_info.full_reset <= reset_src;
    end
  end
  // reset request follows the synchronised sources awake or asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reset_req <= 1'b0;
    end else begin
      full_reset_req <= reset_src;
    end
  end
  assign vector_addr = `SWC_VECTOR;

  // ==========================================================
  // clock and hold controls
  // ==========================================================
  logic asleep;
  assign asleep = state_r != swc_pkg::SWC_RUN;
  // cpu clock drops on the entry edge itself, so no instruction slips past
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
    end else begin
      cpu_clk_en <= !(asleep || entering);
    end
  end
  // ports freeze together with the clock stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hold <= 1'b0;
    end else begin
      io_hold <= asleep || entering;
    end
  end
  // watchdog only keeps counting in sleep when software allowed it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_run_en <= 1'b1;
    end else begin
      watchdog_run_en <= !asleep || ctrl_r[`SWC_CTRL_WDTSLP_BIT];
    end
  end
  // low-frequency oscillator is never stopped by this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_freq_internal_osc_en <= 1'b1;
    end else begin
      low_freq_internal_osc_en <= 1'b1;
    end
  end
  // converter keeps going only on its own oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_osc_en <= 1'b1;
    end else begin
      converter_osc_en <= !asleep || converter_internal_osc_sel;
    end
  end
  // timer1 stops in sleep only when it counts the cpu clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_run_en <= 1'b1;
    end else begin
      timer1_run_en <= !asleep || (timer1_clk_sel != 2'h0);
    end
  end
endmodule

// ---- shared/swc_pkg.sv ----
// types for sleep/wake control
package swc_pkg;
  typedef enum logic [1:0] {
    SWC_RUN = 2'b00,
    SWC_SLEEP = 2'b01,
    SWC_OST = 2'b11,
    SWC_RESUME = 2'b10
  } swc_state_e;
  // wake cause report to the core
  typedef struct packed {
    logic resume;
    logic take_vector;
    logic full_reset;
  } swc_wake_s;
endpackage

// ---- shared/swc_regs.svh ----
// register offsets, field positions, reset values and timing counts for sleep/wake control
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// apb byte addresses
`define SWC_FLAGS3_OFF 12'h000
`define SWC_PWMFLAGS_OFF 12'h004
`define SWC_ENABLE3_OFF 12'h008
`define SWC_ENABLE4_OFF 12'h00c
`define SWC_CTRL_OFF 12'h010
`define SWC_STATUS_OFF 12'h014
// field positions
`define SWC_CAPCOMP3_BIT 4
`define SWC_CTRL_GIE_BIT 0
`define SWC_CTRL_PERIPHERAL_IRQ_ENABLE_BIT 1
`define SWC_CTRL_WDTSLP_BIT 2
`define SWC_CTRL_XTAL_BIT 3
`define SWC_ST_TO_BIT 4
`define SWC_ST_PD_BIT 3
`define SWC_ST_SLEEP_BIT 0
// reset values
`define SWC_FLAGS_RST 8'h00
`define SWC_CTRL_RST 8'h00
// timing
`define SWC_OST_PERIODS 1024
`define SWC_VECTOR 16'h0004
`endif

// ---- sim/swc_chk.sv ----
// checker for sleep entry, clock gating and held outputs
`timescale 1ns/1ps
module swc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_instr,
  input wire logic [15:0] core_pc,
  input wire logic ext_irq_wake,
  input wire logic [1:0] timer1_clk_sel,
  input wire logic converter_internal_osc_sel,
  input wire logic cpu_clk_en,
  input wire logic watchdog_clear,
  input wire logic low_freq_internal_osc_en,
  input wire logic converter_osc_en,
  input wire logic timer1_run_en,
  input wire logic io_hold,
  input wire logic [15:0] prefetch_addr,
  input wire logic [15:0] vector_addr,
  input wire logic peripheral_irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // helper: external level passes two flops, so recent history matters
  logic [2:0] ext_h;
  logic quiet;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_h <= 3'h0;
    else ext_h <= {ext_h[1:0], ext_irq_wake};
  end
  assign quiet = !peripheral_irq_req && !ext_irq_wake && !(|ext_h);
  // ==========================================
  // assertions
  only_on_instr_a: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr))
    else $error("cpu clock stopped without a power-down strobe");
  sleep_entry_a: assert property (sleep_instr && cpu_clk_en && quiet |=> !cpu_clk_en)
    else $error("cpu clock kept running after power-down");
  entry_wdt_a: assert property (sleep_instr && cpu_clk_en && quiet |-> ##[1:2] watchdog_clear)
    else $error("watchdog not cleared on sleep entry");
  io_freeze_a: assert property ($fell(cpu_clk_en) |-> io_hold)
    else $error("ports not held on sleep entry");
  prefetch_next_a: assert property (sleep_instr && cpu_clk_en && quiet
    |=> prefetch_addr == $past(core_pc) + 16'h1)
    else $error("prefetch address is not pc plus one");
  vector_fixed_a: assert property (vector_addr == 16'h0004)
    else $error("interrupt vector moved");
  lfosc_on_a: assert property (low_freq_internal_osc_en)
    else $error("low frequency oscillator stopped");
  timer1_run_a: assert property (!cpu_clk_en && timer1_clk_sel != 2'h0 |-> timer1_run_en)
    else $error("timer1 stopped in sleep on a sleep clock");
  adc_osc_a: assert property (!cpu_clk_en && converter_internal_osc_sel |-> converter_osc_en)
    else $error("converter oscillator stopped in sleep");
endmodule
bind swc_sleep_wakeup_control swc_chk u_swc_chk (.pclk, .presetn, .sleep_instr, .core_pc, .ext_irq_wake,
  .timer1_clk_sel, .converter_internal_osc_sel, .cpu_clk_en, .watchdog_clear, .low_freq_internal_osc_en,
  .converter_osc_en, .timer1_run_en, .io_hold, .prefetch_addr, .vector_addr, .peripheral_irq_req);

// ---- sim/swc_core_model.sv ----
// core model issuing the power-down instruction strobe
`timescale 1ns/1ps
module swc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [15:0] pc_in,
  output logic sleep_instr,
  output logic [15:0] core_pc
);
  // one strobe per request; the word after it is a nop in this image
  // pc keeps changing outside the strobe so a stale capture shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      core_pc <= 16'h0000;
    end else begin
      sleep_instr <= go;
      core_pc <= go ? pc_in : ~core_pc;
    end
  end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for sleep/wake control
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, go = 0;
  logic cc3 = 0, ext = 0, wdt_to = 0, tick = 0, adc_sel = 1, pready, pslverr, sleep_instr;
  logic cpu_clk_en, wclr, irq, tv;
  logic mrst_n = 1, mrst_en = 0, frst, wrun, hold, t1run, cvon;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, pwm_t = 4'h0, pwm_s = 4'h0;
  logic [15:0] core_pc, pf, pc = 16'h0;
  logic [1:0] t1_sel = 2'h1;
  swc_pkg::swc_wake_s wk;
  int fails = 0, checked = 0, nclr = 0, nres = 0, c;
  // ==========================================
  // clock, oscillator ticks and output monitors
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) tick <= ~tick;
  always @(posedge pclk) begin
    if (wclr === 1'b1) nclr <= nclr + 1;
    if (wk.resume === 1'b1) begin
      nres <= nres + 1;
      tv <= wk.take_vector;
    end
  end
  swc_sleep_wakeup_control u_swc_sleep_wakeup_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_instr, .core_pc, .capcomp3_event(cc3),
    .pwm_timebase_event(pwm_t), .pwm_shutdown_event(pwm_s), .ext_irq_wake(ext), .watchdog_timeout(wdt_to),
    .master_reset_pin_n(mrst_n), .master_reset_enable(mrst_en), .brownout_reset(1'b0), .brownout_enable(1'b0),
    .osc_tick(tick), .timer1_clk_sel(t1_sel), .converter_internal_osc_sel(adc_sel), .cpu_clk_en,
    .watchdog_clear(wclr), .watchdog_run_en(wrun), .low_freq_internal_osc_en(), .converter_osc_en(cvon),
    .timer1_run_en(t1run), .io_hold(hold), .prefetch_addr(pf), .full_reset_req(frst), .vector_addr(), .wake_info(wk),
    .peripheral_irq_req(irq));
  swc_core_model u_swc_core_model (.pclk, .presetn, .go, .pc_in(pc), .sleep_instr, .core_pc);
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rd, e, nm);
  endtask
  task automatic ev(input logic [3:0] t, input logic [3:0] s, input logic k);
    @(posedge pclk);
    pwm_t <= t; pwm_s <= s; cc3 <= k;
    @(posedge pclk);
    pwm_t <= 4'h0; pwm_s <= 4'h0; cc3 <= 1'b0;
  endtask
  task automatic slp(input logic [15:0] p);
    @(posedge pclk);
    go <= 1; pc <= p;
    @(posedge pclk);
    go <= 0;
    repeat (3) @(posedge pclk);
  endtask
  // bounded wait: a slow wake counts as a failed check afterwards
  task automatic wake_wait(input int n);
    int i = 0;
    while (cpu_clk_en !== 1'b1 && i < n) begin
      @(posedge pclk);
      i++;
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rdc(12'h014, 32'h18, "status reset");
    rdc(12'h000, 32'h0, "flags3 reset");
    rdc(12'h004, 32'h0, "pwm reset");
    rdc(12'h020, 32'h0, "unmapped");
    chk(err, 1'b1, "slverr");
  endtask
  task automatic t_flags;
    ev(4'ha, 4'h5, 1'b1);
    rdc(12'h000, 32'h10, "cc3 flag");
    rdc(12'h004, 32'ha5, "pwm flags");
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, 12'h000, 32'hff);
    rdc(12'h000, 32'h10, "flags3 rw");
    apb(1'b1, 12'h004, 32'h3c);
    rdc(12'h004, 32'h3c, "pwm rw");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h0, "flags3 clear");
  endtask
  task automatic t_wdt;
    apb(1'b1, 12'h010, 32'h4);
    c = nclr;
    slp(16'h0100);
    chk(cpu_clk_en, 1'b0, "asleep");
    chk(pf, 16'h0101, "prefetch");
    chk(nclr, c + 1, "entry clear");
    rdc(12'h014, 32'h11, "sleep status");
    chk(wrun, 1'b1, "wdt runs");
    chk(hold, 1'b1, "io hold");
    ev(4'h1, 4'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chk(cpu_clk_en, 1'b0, "no enable");
    @(posedge pclk) wdt_to <= 1;
    @(posedge pclk) wdt_to <= 0;
    wake_wait(20);
    chk(cpu_clk_en, 1'b1, "wdt wake");
    chk(nclr, c + 2, "wake clear");
    rdc(12'h014, 32'h0, "wdt status");
    apb(1'b1, 12'h004, 32'h0);
  endtask
  task automatic t_irq;
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h010, 32'h3);
    c = nres;
    slp(16'h0200);
    ev(4'h0, 4'h1, 1'b0);
    wake_wait(20);
    chk(cpu_clk_en, 1'b1, "irq wake");
    repeat (2) @(posedge pclk);
    chk(nres, c + 1, "resume");
    chk(tv, 1'b1, "vector");
    rdc(12'h014, 32'h10, "irq status");
    chk(irq, 1'b1, "irq req");
  endtask
  // flag left pending with global enable off: sleep must do nothing
  task automatic t_noop;
    apb(1'b1, 12'h010, 32'h2);
    c = nclr;
    slp(16'h0300);
    chk(cpu_clk_en, 1'b1, "noop run");
    chk(nclr, c, "noop wdt");
    rdc(12'h014, 32'h10, "noop status");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
  endtask
  // crystal mode: 1024 ticks at one tick per two cycles
  task automatic t_xtal;
    apb(1'b1, 12'h010, 32'h8);
    c = nres;
    slp(16'h0400);
    @(posedge pclk) ext <= 1;
    repeat (1800) @(posedge pclk);
    chk(cpu_clk_en, 1'b0, "ost wait");
    chk(wrun, 1'b0, "wdt stopped");
    wake_wait(400);
    chk(cpu_clk_en, 1'b1, "ost done");
    @(posedge pclk) ext <= 0;
    chk(nres, c + 1, "ext resume");
    chk(tv, 1'b0, "inline");
  endtask
  // master reset pin while asleep: full reset, status back to reset values
  task automatic t_rst;
    apb(1'b1, 12'h010, 32'h0);
    t1_sel <= 2'h0;
    adc_sel <= 1'b0;
    slp(16'h0500);
    chk(t1run, 1'b0, "timer1 stop");
    chk(cvon, 1'b0, "adc osc stop");
    mrst_en <= 1'b1;
    mrst_n <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(frst, 1'b1, "full reset");
    chk(cpu_clk_en, 1'b1, "reset run");
    rdc(12'h014, 32'h18, "reset status");
    mrst_n <= 1'b1;
    mrst_en <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_flags;
    t_wdt;
    t_irq;
    t_noop;
    t_xtal;
    t_rst;
    end_of_test;
  end
  // watchdog: the run needs about 2200 cycles
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
endmodule
